// *** design/xyps_pkg.sv ***
// Purpose : shared constants and types for the x-y plotter output sequencer
// Assumes : 100 MHz sys_clk, synchronous active-low reset
// Notes   : dac codes are 12 bit, full scale of the vertical range is 10.64 V
package xyps_pkg;

	// ----------------------------------------------------------------
	// dac scaling
	// ----------------------------------------------------------------
	localparam int          XYPS_DAC_W      = 12;
	localparam int          XYPS_IDX_W      = 10;
	// horizontal: code 0 = 0 V, code FFF = 10.0 V
	localparam logic [11:0] XYPS_X_ZERO     = 12'h000;
	localparam logic [11:0] XYPS_X_FULL     = 12'hFFF;
	// vertical: code FFF = 10.64 V, so 10.4 V is code 0xFA4
	localparam logic [11:0] XYPS_Y_ZERO     = 12'h000;
	localparam logic [11:0] XYPS_Y_FULL     = 12'hFA4;
	// one amplitude step of about 0.33 V, 32 steps cover the full range
	localparam logic [11:0] XYPS_Y_STEP     = 12'h080;
	localparam int          XYPS_MAX_STEPS  = 32;

	// ----------------------------------------------------------------
	// trace geometry
	// ----------------------------------------------------------------
	localparam int          XYPS_POINTS     = 1001;
	localparam logic [9:0]  XYPS_LAST_PT    = 10'h3E8;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          XYPS_CLK_MHZ    = 100;
	localparam int          XYPS_STEP_MS    = 17;
	localparam int          XYPS_STEP_CYC   = XYPS_STEP_MS * 1000 * XYPS_CLK_MHZ;
	localparam int          XYPS_PEN_MS     = 2000;
	localparam int          XYPS_PEN_CYC    = XYPS_PEN_MS * 1000 * XYPS_CLK_MHZ;

	// ----------------------------------------------------------------
	// modes and commands
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		XYPS_CMD_LOWER_LEFT  = 2'h0,
		XYPS_CMD_UPPER_RIGHT = 2'h1,
		XYPS_CMD_MEM_PLOT    = 2'h2,
		XYPS_CMD_SWEEP_PLOT  = 2'h3
	} xyps_cmd_t;

	typedef struct packed
	{
		logic [11:0] x;
		logic [11:0] y;
		logic        pen_down;
	} xyps_out_t;

	typedef struct packed
	{
		logic        valid;
		xyps_cmd_t   cmd;
	} xyps_sel_t;

endpackage

// *** design/xyps_slew.sv ***
// Purpose : step-limited vertical slew toward a target code
// Assumes : target stable while busy is high
// Notes   : each step is held at least STEP_CYC cycles; last step lands exactly
`timescale 1ns/1ns
module xyps_slew #(
	parameter int STEP_CYC = xyps_pkg::XYPS_STEP_CYC
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// control
	input  wire logic        start,
	input  wire logic        jump,
	input  wire logic [11:0] target,
	// result
	output logic      [11:0] level,
	output logic             busy
);
	import xyps_pkg::*;

	logic [11:0] level_q, level_d;
	logic [31:0] tmr_q, tmr_d;
	logic        busy_q, busy_d;
	logic [11:0] diff;

	always_comb
	begin
		level_d = level_q;
		tmr_d   = tmr_q;
		busy_d  = busy_q;
		diff    = (target > level_q) ? target - level_q : level_q - target;
		if (jump)
		begin
			level_d = target;
			busy_d  = 1'b0;
			tmr_d   = 32'h0;
		end
		else if (start)
		begin
			busy_d = (target != level_q);
			tmr_d  = 32'h0;
		end
		else if (busy_q)
		begin
			if (tmr_q >= 32'(STEP_CYC - 1))
			begin
				tmr_d = 32'h0;
				// the final, partial step lands on the target exactly
				if (diff <= XYPS_Y_STEP) //RULE_05
				begin
					level_d = target;
					busy_d  = 1'b0;
				end
				else if (target > level_q)
					level_d = level_q + XYPS_Y_STEP;
				else
					level_d = level_q - XYPS_Y_STEP;
			end
			else
				tmr_d = tmr_q + 32'h1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			level_q <= 12'h000;
			tmr_q   <= 32'h0;
			busy_q  <= 1'b0;
		end
		else
		begin
			level_q <= level_d;
			tmr_q   <= tmr_d;
			busy_q  <= busy_d;
		end
	end

	assign level = level_q;
	assign busy  = busy_q;

	// level never moves before a full step time has run, except on a jump
	property p_step_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		(busy_q && !jump && !start && level_d != level_q) |-> tmr_q == 32'(STEP_CYC - 1);
	endproperty
	a_step_hold: assert property (p_step_hold) else $error("vertical step shorter than step time"); //RULE_05

	// no single slewed move, partial last step included, exceeds one amplitude step
	property p_step_size;
		@(posedge sys_clk) disable iff (!rst_n)
		(busy_q && !jump && !start) |=>
			((level_q >= $past(level_q)) ? (level_q - $past(level_q)) : ($past(level_q) - level_q)) <= XYPS_Y_STEP;
	endproperty
	a_step_size: assert property (p_step_size) else $error("vertical step larger than one step"); //RULE_05

	property p_step_bound;
		@(posedge sys_clk) disable iff (!rst_n)
		(busy_q && !jump && !start) |=> (level_q == $past(level_q))
			|| (level_q == $past(target))
			|| (level_q - $past(level_q) == XYPS_Y_STEP)
			|| ($past(level_q) - level_q == XYPS_Y_STEP);
	endproperty
	a_step_bound: assert property (p_step_bound) else $error("vertical step size wrong"); //RULE_05

endmodule

// *** design/xyps_top.sv ***
// Purpose : x-y recorder output sequencer: alignment modes, memory plot, sweep plot
// Assumes : all inputs synchronous to sys_clk; trace data answers an index combinationally
// Notes   : panel and remote selections are merged before the mode logic
// Behaviour
// RULE_01: lower-left cancels plotting, both outputs to zero, pen up.
// RULE_02: upper-right puts x at 10 V, y at 10.4 V, pen up.
// RULE_03: the four modes exclude each other; new selection cancels the old.
// RULE_04: memory plot steps x over 1001 points, independent of sweep.
// RULE_05: memory plot slews y in 0.33 V steps of at least 17 ms, max 32.
// RULE_06: with both traces shown, stored trace first, then after 2 s the current.
// RULE_07: memory plot end lifts pen and goes to upper right.
// RULE_08: pen lowers 2 s after a plot starts, lifts on retrace.
// RULE_09: sweep plot x follows sweep, y follows current trace unlimited.
// RULE_10: sweep plot updates position only at display refresh.
// RULE_11: if sweep runs ahead, plotter waits and resumes where it stopped.
// RULE_12: sweep plot moves to start and lowers pen before sweep trigger.
// RULE_13: single sweep end lifts pen and goes to upper right.
// RULE_14: manual mode moves x to manual point first, then lowers pen.
// RULE_15: manual retune: x tracks or slews, pen down, y held until reached.
// RULE_16: panel and remote selection act identically.
// RULE_17: point index maps linearly from 0 V to full scale.
`timescale 1ns/1ns
module xyps_top #(
	parameter int STEP_CYC = xyps_pkg::XYPS_STEP_CYC,
	parameter int PEN_CYC  = xyps_pkg::XYPS_PEN_CYC
) (
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	// mode selection
	input  wire xyps_pkg::xyps_sel_t panel_sel,
	input  wire xyps_pkg::xyps_sel_t remote_sel,
	// trace memory access
	output logic               [9:0] mem_idx,
	output logic                     mem_use_stored,
	input  wire logic         [11:0] mem_data,
	input  wire logic                both_shown,
	// sweep side
	input  wire logic         [11:0] sweep_x,
	input  wire logic         [11:0] cur_y,
	input  wire logic                refresh,
	input  wire logic                sweep_armed,
	input  wire logic                sweep_done,
	input  wire logic                manual_mode,
	// recorder drive
	output xyps_pkg::xyps_out_t      plot_out,
	output logic                     plot_ready,
	output logic               [1:0] mode
);
	import xyps_pkg::*;
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [6:0]
	{
		S_LL    = 7'h01,
		S_UR    = 7'h02,
		S_M_PEN = 7'h04,
		S_M_RUN = 7'h08,
		S_M_GAP = 7'h10,
		S_S_PEN = 7'h20,
		S_S_RUN = 7'h40
	} xyps_state_t;
	xyps_state_t st_q, st_d;
	logic [11:0] x_q, x_d;
	logic [11:0] ys_q, ys_d;
	logic        pen_q, pen_d;
	logic [9:0]  idx_q, idx_d;
	logic        stored_q, stored_d;
	logic [31:0] wait_q, wait_d;
	logic        pt_go_q, pt_go_d;
	logic [1:0]  mode_q, mode_d;

	xyps_sel_t   sel;
	logic        y_busy, y_jump, mem_mode;
	logic [11:0] y_lvl, y_tgt, idx_x;
	logic [21:0] idx_prod;
	// remote has no precedence: either source may select, both act alike
	assign sel      = panel_sel.valid ? panel_sel : remote_sel; //RULE_16
	// linear index to x code: idx * 0xFFF / 1000
	assign idx_prod = 22'(idx_q) * 22'(XYPS_X_FULL); //RULE_17
	assign idx_x    = 12'(idx_prod / 22'(XYPS_LAST_PT));
	assign mem_mode = (st_q == S_M_PEN) || (st_q == S_M_RUN) || (st_q == S_M_GAP);

	// ----------------------------------------------------------------
	// vertical slew limiter
	// ----------------------------------------------------------------
	// outside a memory run the level snaps: to the held code, or to zero while retracing
	assign y_jump = !mem_mode || (st_q != S_M_RUN);
	assign y_tgt  = !mem_mode ? ys_q : ((st_q != S_M_RUN) ? XYPS_Y_ZERO : mem_data);

	xyps_slew #(
		.STEP_CYC (STEP_CYC)
	) u_slew (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.start   (pt_go_q),
		.jump    (y_jump),
		.target  (y_tgt),
		.level   (y_lvl),
		.busy    (y_busy)
	);

	// ----------------------------------------------------------------
	// mode sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		st_d     = st_q;
		x_d      = x_q;
		ys_d     = ys_q;
		pen_d    = pen_q;
		idx_d    = idx_q;
		stored_d = stored_q;
		wait_d   = wait_q;
		pt_go_d  = 1'b0;
		mode_d   = mode_q;
		if (sel.valid)
		begin
			// any selection cancels whatever mode was running
			mode_d = sel.cmd; //RULE_03
			wait_d = 32'h0;
			unique case (sel.cmd)
				XYPS_CMD_LOWER_LEFT:
				begin
					st_d  = S_LL; //RULE_01
					x_d   = XYPS_X_ZERO;
					ys_d  = XYPS_Y_ZERO;
					pen_d = 1'b0;
				end
				XYPS_CMD_UPPER_RIGHT:
				begin
					st_d  = S_UR; //RULE_02
					x_d   = XYPS_X_FULL;
					ys_d  = XYPS_Y_FULL;
					pen_d = 1'b0;
				end
				XYPS_CMD_MEM_PLOT:
				begin
					st_d     = S_M_PEN;
					idx_d    = 10'h000;
					x_d      = XYPS_X_ZERO;
					pen_d    = 1'b0;
					stored_d = both_shown; //RULE_06
				end
				XYPS_CMD_SWEEP_PLOT:
				begin
					st_d  = S_S_PEN; //RULE_12
					x_d   = sweep_x; //RULE_14
					ys_d  = cur_y;
					pen_d = 1'b0;
				end
			endcase
		end
		else
		begin
			unique case (st_q)
				S_LL, S_UR: st_d = st_q;
				S_M_PEN, S_M_GAP:
				begin
					x_d = XYPS_X_ZERO;
					if (wait_q >= 32'(PEN_CYC - 1))
					begin
						wait_d  = 32'h0;
						st_d    = S_M_RUN;
						pen_d   = 1'b1; //RULE_08
						idx_d   = 10'h000;
						pt_go_d = 1'b1;
					end
					else
						wait_d = wait_q + 32'h1;
				end
				S_M_RUN:
				begin
					x_d = idx_x; //RULE_04
					if (!y_busy && !pt_go_q)
					begin
						if (idx_q == XYPS_LAST_PT)
						begin
							if (stored_q)
							begin
								// retrace between traces with the pen lifted
								st_d     = S_M_GAP; //RULE_06
								stored_d = 1'b0;
								pen_d    = 1'b0; //RULE_08
							end
							else
							begin
								st_d   = S_UR; //RULE_07
								mode_d = XYPS_CMD_UPPER_RIGHT;
								x_d    = XYPS_X_FULL;
								ys_d   = XYPS_Y_FULL;
								pen_d  = 1'b0;
							end
						end
						else
						begin
							idx_d   = idx_q + 10'h001;
							pt_go_d = 1'b1;
						end
					end
				end
				S_S_PEN:
				begin
					// hold position while the pen settles; the sweep stays armed
					if (wait_q >= 32'(PEN_CYC - 1))
					begin
						st_d  = S_S_RUN;
						pen_d = 1'b1; //RULE_12
					end
					else
						wait_d = wait_q + 32'h1;
				end
				S_S_RUN:
				begin
					if (sweep_done && !manual_mode)
					begin
						st_d   = S_UR; //RULE_13
						mode_d = XYPS_CMD_UPPER_RIGHT;
						x_d    = XYPS_X_FULL;
						ys_d   = XYPS_Y_FULL;
						pen_d  = 1'b0;
					end
					else if (refresh)
					begin
						// outside manual mode only forward moves at refresh; a sweep that got ahead is caught next pass
						if (manual_mode || sweep_x >= x_q) //RULE_11
						begin
							x_d = sweep_x; //RULE_09 RULE_10 RULE_15
							// y held while a manual retune is still moving x
							if (!(manual_mode && sweep_x != x_q))
								ys_d = cur_y; //RULE_15
						end
					end
				end
				default: st_d = S_LL;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			st_q     <= S_LL;
			x_q      <= 12'h000;
			ys_q     <= 12'h000;
			pen_q    <= 1'b0;
			idx_q    <= 10'h000;
			stored_q <= 1'b0;
			wait_q   <= 32'h0;
			pt_go_q  <= 1'b0;
			mode_q   <= 2'h0;
		end
		else
		begin
			st_q     <= st_d;
			x_q      <= x_d;
			ys_q     <= ys_d;
			pen_q    <= pen_d;
			idx_q    <= idx_d;
			stored_q <= stored_d;
			wait_q   <= wait_d;
			pt_go_q  <= pt_go_d;
			mode_q   <= mode_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign plot_out          = {x_q, (mem_mode ? y_lvl : ys_q), pen_q};
	assign mem_idx           = idx_q;
	assign mem_use_stored    = stored_q;
	assign plot_ready        = (st_q == S_S_RUN) && sweep_armed;
	assign mode              = mode_q;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_sel_ll;
		sel.valid && sel.cmd == XYPS_CMD_LOWER_LEFT;
	endsequence
	property p_lower_left;
		@(posedge sys_clk) disable iff (!rst_n)
		s_sel_ll |=> plot_out.x == XYPS_X_ZERO && plot_out.y == XYPS_Y_ZERO && !plot_out.pen_down;
	endproperty
	a_lower_left: assert property (p_lower_left) else $error("lower-left not reached"); //RULE_01
	property p_upper_right;
		@(posedge sys_clk) disable iff (!rst_n)
		(sel.valid && sel.cmd == XYPS_CMD_UPPER_RIGHT) |=>
			plot_out.x == XYPS_X_FULL && plot_out.y == XYPS_Y_FULL && !plot_out.pen_down;
	endproperty
	a_upper_right: assert property (p_upper_right) else $error("upper-right not reached"); //RULE_02
	property p_exclusive;
		@(posedge sys_clk) disable iff (!rst_n)
		sel.valid |=> mode == $past(sel.cmd);
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("selected mode not taken"); //RULE_03
	property p_idx_bound;
		@(posedge sys_clk) disable iff (!rst_n)
		mem_idx <= XYPS_LAST_PT;
	endproperty
	a_idx_bound: assert property (p_idx_bound) else $error("point index beyond last point"); //RULE_04
	sequence s_mem_sel;
		sel.valid && sel.cmd == XYPS_CMD_MEM_PLOT;
	endsequence
	property p_pen_wait;
		@(posedge sys_clk) disable iff (!rst_n)
		s_mem_sel ##1 (!sel.valid)[*8] |-> !plot_out.pen_down;
	endproperty
	a_pen_wait: assert property (p_pen_wait) else $error("pen lowered too early"); //RULE_08
	property p_mem_end;
		@(posedge sys_clk) disable iff (!rst_n)
		(st_q == S_M_RUN && st_d == S_UR) |=> !plot_out.pen_down && plot_out.x == XYPS_X_FULL;
	endproperty
	a_mem_end: assert property (p_mem_end) else $error("memory plot end not parked"); //RULE_07
	property p_sweep_end;
		@(posedge sys_clk) disable iff (!rst_n)
		(st_q == S_S_RUN && sweep_done && !manual_mode && !sel.valid) |=>
			!plot_out.pen_down && plot_out.y == XYPS_Y_FULL;
	endproperty
	a_sweep_end: assert property (p_sweep_end) else $error("sweep plot end not parked"); //RULE_13
	property p_refresh_only;
		@(posedge sys_clk) disable iff (!rst_n)
		(st_q == S_S_RUN && !refresh && !sel.valid && !sweep_done) |=> $stable(plot_out.x);
	endproperty
	a_refresh_only: assert property (p_refresh_only) else $error("x moved without refresh"); //RULE_10
	property p_no_back;
		@(posedge sys_clk) disable iff (!rst_n)
		(st_q == S_S_RUN && !manual_mode && !sel.valid && !sweep_done) |=> plot_out.x >= $past(plot_out.x);
	endproperty
	a_no_back: assert property (p_no_back) else $error("sweep plot moved backward"); //RULE_11
	property p_pen_before_arm;
		@(posedge sys_clk) disable iff (!rst_n)
		plot_ready |-> plot_out.pen_down;
	endproperty
	a_pen_before_arm: assert property (p_pen_before_arm) else $error("ready without pen down"); //RULE_12
endmodule

// *** bench/xyps_recorder.sv ***
// Purpose : behavioural x-y recorder hanging on the plotter outputs
// Assumes : pen_down high lowers the pen onto the paper
// Notes   : counts pen strokes so the bench can see lifts on retrace
`timescale 1ns/1ns
module xyps_recorder
(
	// clock
	input  wire logic                sys_clk,
	// drive from the sequencer
	input  wire xyps_pkg::xyps_out_t drive,
	// observation
	output int                       strokes
);
	import xyps_pkg::*;

	logic pen_q;

	initial strokes = 0;

	// a real recorder only sees pen edges, so count lowerings
	always @(posedge sys_clk)
	begin
		pen_q <= drive.pen_down;
		if (drive.pen_down === 1'b1 && pen_q === 1'b0)
			strokes <= strokes + 1;
	end
endmodule

// *** bench/tb_top.sv ***
// Purpose : self-checking bench for the plotter output sequencer
// Assumes : short step and pen delays so a full memory plot fits the run
// Notes   : inputs change 1 ns after the rising edge
`timescale 1ns/1ns
module tb_top;
	import xyps_pkg::*;

	localparam int STEP = 20;
	localparam int PEN  = 50;

	logic        sys_clk, rst_n, both_shown, refresh, sweep_armed, sweep_done;
	logic        manual_mode, mem_use_stored, plot_ready;
	logic [9:0]  mem_idx;
	logic [11:0] mem_data, sweep_x, cur_y;
	logic [1:0]  mode;
	xyps_sel_t   panel_sel, remote_sel;
	xyps_out_t   plot_out;
	int          bad_count, n_compared, strokes, cyc;

	// first point needs a long slew ending in a partial step
	function automatic logic [11:0] mem_val(input int i);
		return (i == 0) ? 12'h3C0 : (i[0] ? 12'h07E : 12'h000);
	endfunction

	assign mem_data = mem_val(int'(mem_idx));

	xyps_top #(.STEP_CYC(STEP), .PEN_CYC(PEN)) uut (
		.sys_clk(sys_clk), .rst_n(rst_n), .panel_sel(panel_sel), .remote_sel(remote_sel),
		.mem_idx(mem_idx), .mem_use_stored(mem_use_stored), .mem_data(mem_data),
		.both_shown(both_shown), .sweep_x(sweep_x), .cur_y(cur_y), .refresh(refresh),
		.sweep_armed(sweep_armed), .sweep_done(sweep_done), .manual_mode(manual_mode),
		.plot_out(plot_out), .plot_ready(plot_ready), .mode(mode));

	xyps_recorder rec (.sys_clk(sys_clk), .drive(plot_out), .strokes(strokes));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %0t: saw %h expected %h", $time, got, exp);
		end
	endtask

	// panel and remote are separate signals, so back-to-back selects can alternate them
	task automatic sel(input logic remote, input xyps_cmd_t cmd);
		if (remote)
			remote_sel = '{1'b1, cmd};
		else
			panel_sel = '{1'b1, cmd};
		tick(1);
		if (remote)
			remote_sel.valid = 1'b0;
		else
			panel_sel.valid = 1'b0;
	endtask

	task automatic expect_pos(input logic [11:0] x, input logic [11:0] y, input logic pen, input logic [1:0] md);
		chk(plot_out.x, x);
		chk(plot_out.y, y);
		chk(plot_out.pen_down, pen);
		chk(mode, md);
	endtask

	task automatic pen_wait();
		int c;
		c = 0;
		while (plot_out.pen_down !== 1'b1 && c < PEN + 10)
		begin
			tick(1);
			c++;
		end
		chk(plot_out.pen_down, 1'b1);
		chk(c >= PEN - 2, 1'b1);
	endtask

	task automatic pulse_refresh();
		refresh = 1'b1;
		tick(1);
		refresh = 1'b0;
		tick(2);
	endtask

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_align();
		expect_pos(12'h000, 12'h000, 1'b0, 2'h0);
		sel(1'b0, XYPS_CMD_UPPER_RIGHT);
		tick(1);
		expect_pos(XYPS_X_FULL, XYPS_Y_FULL, 1'b0, 2'h1);
		sel(1'b1, XYPS_CMD_LOWER_LEFT);
		tick(1);
		expect_pos(12'h000, 12'h000, 1'b0, 2'h0);
		sel(1'b1, XYPS_CMD_UPPER_RIGHT);
		tick(1);
		expect_pos(XYPS_X_FULL, XYPS_Y_FULL, 1'b0, 2'h1);
		sel(1'b0, XYPS_CMD_MEM_PLOT);
		sel(1'b1, XYPS_CMD_LOWER_LEFT);
		tick(PEN + 5);
		expect_pos(12'h000, 12'h000, 1'b0, 2'h0);
	endtask

	task automatic t_mem();
		int n, since, dy, c, s0, k;
		logic [11:0] px, py;
		logic pp;
		s0 = strokes;
		k = 0;
		both_shown = 1'b1;
		sel(1'b0, XYPS_CMD_MEM_PLOT);
		tick(1);
		expect_pos(12'h000, 12'h000, 1'b0, 2'h2);
		pen_wait();
		n = 0;
		since = STEP;
		c = 0;
		{px, py, pp} = {plot_out.x, plot_out.y, 1'b0};
		while (mode !== 2'h1 && c < 90000)
		begin
			if (plot_out.pen_down && pp && plot_out.y != py)
			begin
				dy = (plot_out.y > py) ? int'(plot_out.y - py) : int'(py - plot_out.y);
				chk(dy <= int'(XYPS_Y_STEP), 1'b1);
				chk(since >= STEP, 1'b1);
				since = 0;
			end
			if (plot_out.pen_down && pp && plot_out.x != px)
			begin
				n++;
				chk(plot_out.x, (n * 4095) / 1000);
				chk(plot_out.y, mem_val(n - 1));
			end
			if (plot_out.pen_down && !pp)
			begin
				k++;
				chk(mem_use_stored, k == 1);
			end
			if (!plot_out.pen_down && pp)
			begin
				chk(n, XYPS_POINTS - 1);
				n = 0;
			end
			{px, py, pp} = {plot_out.x, plot_out.y, plot_out.pen_down};
			tick(1);
			since++;
			c++;
		end
		chk(n, XYPS_POINTS - 1);
		expect_pos(XYPS_X_FULL, XYPS_Y_FULL, 1'b0, 2'h1);
		chk(strokes - s0, 2);
		both_shown = 1'b0;
	endtask

	task automatic t_sweep();
		{manual_mode, sweep_armed, sweep_x, cur_y} = {1'b0, 1'b1, 12'h100, 12'h200};
		sel(1'b1, XYPS_CMD_SWEEP_PLOT);
		tick(1);
		expect_pos(12'h100, 12'h200, 1'b0, 2'h3);
		chk(plot_ready, 1'b0);
		pen_wait();
		chk(plot_ready, 1'b1);
		{sweep_x, cur_y} = {12'h300, 12'h280};
		tick(3);
		chk(plot_out.x, 12'h100);
		pulse_refresh();
		chk({plot_out.x, plot_out.y}, {12'h300, 12'h280});
		sweep_x = 12'h200;
		pulse_refresh();
		chk(plot_out.x, 12'h300);
		sweep_x = 12'h380;
		pulse_refresh();
		chk(plot_out.x, 12'h380);
		sweep_done = 1'b1;
		tick(1);
		sweep_done = 1'b0;
		tick(1);
		expect_pos(XYPS_X_FULL, XYPS_Y_FULL, 1'b0, 2'h1);
	endtask

	task automatic t_manual();
		{manual_mode, sweep_x, cur_y} = {1'b1, 12'h400, 12'h150};
		sel(1'b0, XYPS_CMD_SWEEP_PLOT);
		tick(1);
		chk({plot_out.x, plot_out.pen_down}, {12'h400, 1'b0});
		pen_wait();
		{sweep_x, cur_y} = {12'h100, 12'h500};
		pulse_refresh();
		chk({plot_out.x, plot_out.y, plot_out.pen_down}, {12'h100, 12'h150, 1'b1});
		pulse_refresh();
		chk(plot_out.y, 12'h500);
		sel(1'b1, XYPS_CMD_LOWER_LEFT);
		tick(1);
		expect_pos(12'h000, 12'h000, 1'b0, 2'h0);
		manual_mode = 1'b0;
	endtask

	// reset in mid-plot must drop straight back to the parked lower-left state
	task automatic t_reset();
		sel(1'b1, XYPS_CMD_SWEEP_PLOT);
		tick(PEN + 5);
		chk(plot_out.pen_down, 1'b1);
		rst_n = 1'b0;
		tick(2);
		expect_pos(12'h000, 12'h000, 1'b0, 2'h0);
		rst_n = 1'b1;
		tick(1);
		expect_pos(12'h000, 12'h000, 1'b0, 2'h0);
		chk(mem_idx, 10'h000);
	endtask

	// a hang counts as a mismatch and still reaches the report
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end

	initial
	begin
		{bad_count, n_compared, cyc} = '0;
		{rst_n, both_shown, refresh, sweep_armed, sweep_done, manual_mode} = '0;
		{panel_sel, remote_sel, sweep_x, cur_y} = '0;
		repeat (10) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		t_align();
		t_mem();
		t_sweep();
		t_manual();
		t_reset();
		tally_and_finish();
	end
endmodule
